// [verilog/alcc_pkg.sv]
package alcc_pkg;
    // Byte addresses of the registers on the bus
    localparam logic [7:0] ADDR_CHAN_A = 8'h00;
    localparam logic [7:0] ADDR_CONFIG_ONE = 8'h04;
    localparam logic [7:0] ADDR_STATUS_TWO = 8'h08;
    localparam logic [7:0] ADDR_STATUS_THREE = 8'h0c;
    localparam logic [7:0] ADDR_RESULT_A = 8'h10;
    localparam logic [7:0] ADDR_CMP_ONE = 8'h14;
    localparam logic [7:0] ADDR_CMP_TWO = 8'h18;
    // Field positions
    localparam int CC_CONV_COMPLETE_FLAG_BIT = 7;
    localparam int CC_IRQ_EN_BIT = 6;
    localparam int CC_CH_LSB = 0;
    localparam int CFG_LOW_POWER_BIT = 7;
    localparam int CFG_DIV_LSB = 5;
    localparam int CFG_LONG_SAMPLE_BIT = 4;
    localparam int CFG_MODE_LSB = 2;
    localparam int CFG_CLK_LSB = 0;
    localparam int SC2_ACTIVE_BIT = 7;
    localparam int SC2_TRIG_BIT = 6;
    localparam int SC2_CMP_EN_BIT = 5;
    localparam int SC2_CMP_GT_BIT = 4;
    localparam int SC2_RANGE_BIT = 3;
    localparam int SC2_REF_LSB = 0;
    localparam int SC3_CONT_BIT = 3;
    localparam int SC3_AVG_EN_BIT = 2;
    localparam int SC3_AVG_SEL_LSB = 0;
    localparam logic [7:0] SC2_WRITE_MASK = 8'h7b;
    localparam logic [7:0] SC3_WRITE_MASK = 8'h0f;
    // Reset values
    localparam logic [7:0] RST_CHAN_A = 8'h00;
    localparam logic [7:0] RST_CONFIG_ONE = 8'h00;
    localparam logic [7:0] RST_STATUS_TWO = 8'h00;
    localparam logic [7:0] RST_STATUS_THREE = 8'h00;
    localparam logic [11:0] RST_DATA = 12'h000;
    // Conversion timing in conversion clock ticks
    localparam int SHORT_SAMPLE_TICKS = 4;
    localparam int LONG_SAMPLE_TICKS = 20;
    localparam int MAX_SAMPLE_TICKS = 40;
    // Encodings
    localparam logic [1:0] CLK_BUS = 2'b00;
    localparam logic [1:0] CLK_BUS_HALF = 2'b01;
    localparam logic [1:0] CLK_ALT = 2'b10;
    localparam logic [1:0] CLK_ASYNC = 2'b11;
    localparam logic [1:0] RES_8 = 2'b00;
    localparam logic [1:0] RES_12 = 2'b01;
    localparam logic [1:0] RES_10 = 2'b10;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_DONE = 2'b10
    } alcc_state_t;

    function automatic logic [3:0] alcc_res_bits(input logic [1:0] mode);
        case (mode)
            RES_8: alcc_res_bits = 4'd8;
            RES_10: alcc_res_bits = 4'd10;
            default: alcc_res_bits = 4'd12;
        endcase
    endfunction : alcc_res_bits

    function automatic logic [4:0] alcc_avg_last(input logic [1:0] sel);
        case (sel)
            2'b00: alcc_avg_last = 5'd3;
            2'b01: alcc_avg_last = 5'd7;
            2'b10: alcc_avg_last = 5'd15;
            default: alcc_avg_last = 5'd31;
        endcase
    endfunction : alcc_avg_last

    function automatic logic alcc_cmp_true(input logic [11:0] v, input logic [11:0] c1, input logic [11:0] c2,
                                           input logic gt, input logic range);
        if (!range)
            alcc_cmp_true = gt ? (v >= c1) : (v < c1);
        else if (c1 <= c2)
            alcc_cmp_true = gt ? (v >= c1 && v <= c2) : (v < c1 || v > c2);
        else
            alcc_cmp_true = gt ? (v >= c1 || v <= c2) : (v < c1 && v > c2);
    endfunction : alcc_cmp_true
endpackage : alcc_pkg

// [verilog/alcc_clock_gen.sv]
`timescale 1ns/1ps
module alcc_clock_gen (
    // Clock and reset
    input logic clk_sys,
    input logic resetn,
    // Selection
    input logic [1:0] input_clock_select,
    input logic [1:0] clock_divide_select,
    input logic run_enable,
    // Foreign clock pins
    input logic async_conv_clock,
    input logic alternate_clock,
    // Conversion clock tick
    output logic conv_tick
);
    import alcc_pkg::*;

    logic [2:0] alt_sync;
    logic [2:0] async_sync;
    logic alt_stable;
    logic alt_prev;
    logic async_stable;
    logic async_prev;
    logic half_phase;
    logic [2:0] div_cnt;
    logic src_tick;

    // Foreign clocks are sampled; a level counts once two stages agree
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            alt_sync <= 3'h0;
            async_sync <= 3'h0;
            alt_stable <= 1'b0;
            async_stable <= 1'b0;
            alt_prev <= 1'b0;
            async_prev <= 1'b0;
        end
        else
        begin
            alt_sync <= {alt_sync[1:0], alternate_clock};
            async_sync <= {async_sync[1:0], async_conv_clock};
            if (alt_sync[2] == alt_sync[1])
                alt_stable <= alt_sync[1];
            if (async_sync[2] == async_sync[1])
                async_stable <= async_sync[1];
            alt_prev <= alt_stable;
            async_prev <= async_stable;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            half_phase <= 1'b0;
        else
            half_phase <= ~half_phase;
    end

    // In Normal Stop only the async source keeps ticking; run_enable drops for the others
    always_comb
    begin
        case (input_clock_select)
            CLK_BUS: src_tick = 1'b1;
            CLK_BUS_HALF: src_tick = half_phase;
            CLK_ALT: src_tick = alt_stable & ~alt_prev;
            default: src_tick = async_stable & ~async_prev;
        endcase
    end

    // Divide by 1, 2, 4 or 8
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            div_cnt <= 3'h0;
        else if (!run_enable)
            div_cnt <= 3'h0;
        else if (src_tick)
            div_cnt <= div_cnt + 3'h1;
    end

    always_comb
    begin
        case (clock_divide_select)
            2'b00: conv_tick = run_enable & src_tick;
            2'b01: conv_tick = run_enable & src_tick & div_cnt[0];
            2'b10: conv_tick = run_enable & src_tick & (div_cnt[1:0] == 2'b11);
            default: conv_tick = run_enable & src_tick & (div_cnt == 3'b111);
        endcase
    end
endmodule : alcc_clock_gen

// [verilog/alcc_conv_control.sv]
// The Wishbone slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module alcc_conv_control #(
    parameter int SHORT_SAMPLE = alcc_pkg::SHORT_SAMPLE_TICKS,
    parameter int LONG_SAMPLE = alcc_pkg::LONG_SAMPLE_TICKS
) (
    // Clock and reset
    input logic clk_sys,
    input logic resetn,
    // Wishbone slave
    input logic wb_cyc_i,
    input logic wb_stb_i,
    input logic wb_we_i,
    input logic [7:0] wb_adr_i,
    input logic [3:0] wb_sel_i,
    input logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Power mode from the power controller
    input logic wait_mode,
    input logic normal_stop,
    input logic low_power_stop,
    // Trigger and foreign clock pins
    input logic hw_trigger,
    input logic async_conv_clock,
    input logic alternate_clock,
    // Analog front end
    input logic [11:0] analog_data,
    output logic sample_hold,
    output logic [4:0] analog_channel,
    output logic [1:0] analog_ref_select,
    output logic analog_low_power,
    // Status
    output logic conv_active,
    output logic conv_irq
);
    import alcc_pkg::*;

    if (SHORT_SAMPLE < 1 || LONG_SAMPLE < SHORT_SAMPLE || LONG_SAMPLE > MAX_SAMPLE_TICKS)
    begin : g_check
        $error("alcc_conv_control: sample lengths out of range");
    end

    logic [7:0] converter_config_one;
    logic [7:0] sc2;
    logic [7:0] sc3;
    logic irq_en;
    logic [4:0] channel;
    logic conv_complete_flag;
    logic [11:0] result;
    logic [11:0] cv1;
    logic [11:0] cv2;
    alcc_state_t state;
    logic [5:0] tick_cnt;
    logic [4:0] avg_idx;
    logic [16:0] acc;
    logic [11:0] final_val;
    logic stop_lock;
    logic [2:0] trig_sync;
    logic trig_stable;
    logic trig_prev;
    logic [31:0] read_mux;
    logic conv_tick;

    logic bus_req;
    logic bus_commit;
    logic wr;
    logic wr_chan;
    logic rd_result;
    logic hw_edge;
    logic async_sel;
    logic stop_abort;
    logic trig_hw;
    logic cmp_en;
    logic avg_en;
    logic cont;
    logic avg_last;
    logic [5:0] sample_len;
    logic [5:0] conv_len;
    logic conv_end;
    logic [11:0] sample_val;
    logic [16:0] sum;
    logic [16:0] avg_out;
    logic pass;
    logic start_sw;
    logic start_hw;
    logic conv_complete_flag_set;

    // A bus access takes effect at the edge where ack is seen high
    assign bus_req = wb_cyc_i & wb_stb_i;
    assign bus_commit = bus_req & wb_ack_o;
    assign wr = bus_commit & wb_we_i & wb_sel_i[0];
    assign wr_chan = wr && (wb_adr_i == ADDR_CHAN_A);
    assign rd_result = bus_commit && !wb_we_i && (wb_adr_i == ADDR_RESULT_A);

    assign async_sel = converter_config_one[CFG_CLK_LSB +: 2] == CLK_ASYNC;
    assign stop_abort = normal_stop & ~async_sel;
    assign trig_hw = sc2[SC2_TRIG_BIT];
    assign cmp_en = sc2[SC2_CMP_EN_BIT];
    assign avg_en = sc3[SC3_AVG_EN_BIT];
    assign cont = sc3[SC3_CONT_BIT];
    assign avg_last = avg_idx == alcc_avg_last(sc3[SC3_AVG_SEL_LSB +: 2]);
    assign sample_len = converter_config_one[CFG_LONG_SAMPLE_BIT] ? 6'(LONG_SAMPLE) : 6'(SHORT_SAMPLE);
    assign conv_len = 6'(sample_len + {2'b00, alcc_res_bits(converter_config_one[CFG_MODE_LSB +: 2])} + 6'd1);
    assign conv_end = (state == ST_RUN) && conv_tick && (tick_cnt == conv_len - 6'd1);
    assign sample_val = analog_data >> (4'd12 - alcc_res_bits(converter_config_one[CFG_MODE_LSB +: 2]));
    assign sum = acc + {5'b00000, sample_val};
    assign avg_out = sum >> (3'd2 + {1'b0, sc3[SC3_AVG_SEL_LSB +: 2]});
    assign pass = !cmp_en || alcc_cmp_true(final_val, cv1, cv2, sc2[SC2_CMP_GT_BIT], sc2[SC2_RANGE_BIT]);
    assign start_sw = wr_chan & ~trig_hw;
    assign start_hw = hw_edge & trig_hw;
    assign conv_complete_flag_set = (state == ST_DONE) && pass && !low_power_stop;

    // Trigger pin passes three stages
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            trig_sync <= 3'h0;
            trig_stable <= 1'b0;
            trig_prev <= 1'b0;
        end
        else
        begin
            trig_sync <= {trig_sync[1:0], hw_trigger};
            if (trig_sync[2] == trig_sync[1])
                trig_stable <= trig_sync[1];
            trig_prev <= trig_stable;
        end
    end
    assign hw_edge = trig_stable & ~trig_prev;

    alcc_clock_gen alcc_clock_gen_inst (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .input_clock_select(converter_config_one[CFG_CLK_LSB +: 2]),
        .clock_divide_select(converter_config_one[CFG_DIV_LSB +: 2]),
        .run_enable((state == ST_RUN) && !stop_abort),
        .async_conv_clock(async_conv_clock),
        .alternate_clock(alternate_clock),
        .conv_tick(conv_tick)
    );

    // Sequencer; Wait mode has no effect on it, only stop modes do
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            state <= ST_IDLE;
        else if (low_power_stop)
            state <= ST_IDLE;
        else if (stop_abort)
            state <= ST_IDLE;
        else if (wr_chan)
            state <= trig_hw ? ST_IDLE : ST_RUN;
        else
        begin
            case (state)
                ST_IDLE:
                    if (start_hw)
                        state <= ST_RUN;
                ST_RUN:
                    if (conv_end && (!avg_en || avg_last))
                        state <= ST_DONE;
                ST_DONE:
                    if (cont || start_hw)
                        state <= ST_RUN;
                    else
                        state <= ST_IDLE;
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // Tick counter and averaging accumulator
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            tick_cnt <= 6'h00;
            avg_idx <= 5'h00;
            acc <= 17'h00000;
            final_val <= RST_DATA;
        end
        else if (low_power_stop)
        begin
            tick_cnt <= 6'h00;
            avg_idx <= 5'h00;
            acc <= 17'h00000;
            final_val <= RST_DATA;
        end
        else
        begin
            if (state != ST_RUN || wr_chan || conv_end)
                tick_cnt <= 6'h00;
            else if (conv_tick)
                tick_cnt <= tick_cnt + 6'h01;
            if (state != ST_RUN || wr_chan)
            begin
                avg_idx <= 5'h00;
                acc <= 17'h00000;
            end
            else if (conv_end && avg_en && !avg_last)
            begin
                avg_idx <= avg_idx + 5'h01;
                acc <= sum;
            end
            if (conv_end)
                final_val <= avg_en ? avg_out[11:0] : sample_val;
        end
    end

    // Completion flag, result and stop hold; a set wins over a clear
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            conv_complete_flag <= 1'b0;
            result <= RST_DATA;
            stop_lock <= 1'b0;
        end
        else if (low_power_stop)
        begin
            conv_complete_flag <= 1'b0;
            result <= RST_DATA;
            stop_lock <= 1'b0;
        end
        else
        begin
            if (conv_complete_flag_set)
                conv_complete_flag <= 1'b1;
            else if (wr_chan || rd_result)
                conv_complete_flag <= 1'b0;
            if (conv_complete_flag_set && !stop_lock)
                result <= final_val;
            if (!normal_stop)
                stop_lock <= 1'b0;
            else if (conv_complete_flag_set && irq_en)
                stop_lock <= 1'b1;
        end
    end

    // Software registers; power modes other than Low-Power Stop leave them alone
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            converter_config_one <= RST_CONFIG_ONE;
            sc2 <= RST_STATUS_TWO;
            sc3 <= RST_STATUS_THREE;
            irq_en <= RST_CHAN_A[CC_IRQ_EN_BIT];
            channel <= RST_CHAN_A[CC_CH_LSB +: 5];
            cv1 <= RST_DATA;
            cv2 <= RST_DATA;
        end
        else if (low_power_stop)
        begin
            converter_config_one <= RST_CONFIG_ONE;
            sc2 <= RST_STATUS_TWO;
            sc3 <= RST_STATUS_THREE;
            irq_en <= RST_CHAN_A[CC_IRQ_EN_BIT];
            channel <= RST_CHAN_A[CC_CH_LSB +: 5];
            cv1 <= RST_DATA;
            cv2 <= RST_DATA;
        end
        else if (wr)
        begin
            case (wb_adr_i)
                ADDR_CHAN_A:
                begin
                    irq_en <= wb_dat_i[CC_IRQ_EN_BIT];
                    channel <= wb_dat_i[CC_CH_LSB +: 5];
                end
                ADDR_CONFIG_ONE: converter_config_one <= wb_dat_i[7:0];
                ADDR_STATUS_TWO: sc2 <= wb_dat_i[7:0] & SC2_WRITE_MASK;
                ADDR_STATUS_THREE: sc3 <= wb_dat_i[7:0] & SC3_WRITE_MASK;
                ADDR_CMP_ONE: cv1 <= wb_dat_i[11:0];
                ADDR_CMP_TWO: cv2 <= wb_dat_i[11:0];
                default: converter_config_one <= converter_config_one;
            endcase
        end
    end

    always_comb
    begin
        case (wb_adr_i)
            ADDR_CHAN_A: read_mux = {24'h000000, conv_complete_flag, irq_en, 1'b0, channel};
            ADDR_CONFIG_ONE: read_mux = {24'h000000, converter_config_one};
            ADDR_STATUS_TWO: read_mux = {24'h000000, conv_active, sc2[6:0]};
            ADDR_STATUS_THREE: read_mux = {24'h000000, sc3};
            ADDR_RESULT_A: read_mux = {20'h00000, result};
            ADDR_CMP_ONE: read_mux = {20'h00000, cv1};
            ADDR_CMP_TWO: read_mux = {20'h00000, cv2};
            default: read_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= bus_req & ~wb_ack_o;
            if (bus_req && !wb_ack_o)
                wb_dat_o <= read_mux;
        end
    end

    assign conv_active = state != ST_IDLE;
    assign conv_irq = conv_complete_flag & irq_en;
    assign sample_hold = (state == ST_RUN) && (tick_cnt < sample_len);
    assign analog_channel = channel;
    assign analog_ref_select = sc2[SC2_REF_LSB +: 2];
    assign analog_low_power = converter_config_one[CFG_LOW_POWER_BIT];

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    wait_keeps_running_a: assert property (
        wait_mode && state == ST_RUN && !normal_stop && !low_power_stop && !wr_chan |=> state != ST_IDLE)
        else $error("conversion dropped in wait mode");
    hw_start_taken_a: assert property (
        state == ST_IDLE && start_hw && !normal_stop && !low_power_stop && !wr_chan |=> state == ST_RUN)
        else $error("hardware trigger not taken");
    plain_done_flag_a: assert property (
        state == ST_DONE && !cmp_en && !avg_en && !low_power_stop |=> conv_complete_flag && (irq_en -> conv_irq))
        else $error("completion flag not set");
    avg_count_done_a: assert property (
        $rose(conv_complete_flag) && $past(avg_en) |-> $past(avg_idx) == alcc_avg_last($past(sc3[1:0])))
        else $error("average flagged early");
    cmp_fail_idle_a: assert property (
        state == ST_DONE && !pass && !cont && !start_hw && !wr_chan |=> state == ST_IDLE && !$rose(conv_complete_flag))
        else $error("failed compare did not go idle");
    stop_abort_idle_a: assert property (
        normal_stop && !async_sel |=> state == ST_IDLE)
        else $error("stop did not abort");
    stop_regs_kept_a: assert property (
        normal_stop && !low_power_stop && !wr |=> $stable(converter_config_one) && $stable(sc2) && $stable(cv1))
        else $error("register changed in stop");
    stop_result_held_a: assert property (
        stop_lock && normal_stop && !low_power_stop |=> $stable(result))
        else $error("stop result overwritten");
    lp_stop_reset_a: assert property (
        low_power_stop |=> converter_config_one == RST_CONFIG_ONE && sc2 == RST_STATUS_TWO && !conv_complete_flag && state == ST_IDLE)
        else $error("low-power stop left state");
    cont_restart_a: assert property (
        state == ST_DONE && cont && !low_power_stop && !stop_abort && !wr_chan |=> state == ST_RUN)
        else $error("continuous conversion not restarted");
endmodule : alcc_conv_control

// [tb/alcc_conv_control_tb.sv]
`timescale 1ns/1ps
module alcc_conv_control_tb;
    import alcc_pkg::*;
    logic clk_sys, resetn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic wait_mode, normal_stop, low_power_stop, hw_trigger, async_conv_clock, alternate_clock;
    logic [11:0] analog_data;
    logic sample_hold, analog_low_power, conv_active, conv_irq;
    logic [4:0] analog_channel;
    logic [1:0] analog_ref_select;
    logic [2:0] div = 3'h0;
    int fail_count = 0;
    int n_tests = 0;
    int cyc = 0;

    alcc_conv_control alcc_conv_control_inst (.clk_sys, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wait_mode, .normal_stop, .low_power_stop, .hw_trigger,
        .async_conv_clock, .alternate_clock, .analog_data, .sample_hold, .analog_channel, .analog_ref_select,
        .analog_low_power, .conv_active, .conv_irq);

    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // Slow foreign clocks, far below the bus rate so the synchronisers see every edge
    assign async_conv_clock = div[1];
    assign alternate_clock = div[2];

    always @(posedge clk_sys)
    begin
        div <= div + 3'h1;
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fail_count++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (fail_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict

    // Classic single cycle; ack and read data taken at the rising edge, request dropped right after it
    task automatic bus(input logic we, input logic [7:0] a, input logic [11:0] d, output logic [11:0] q);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'h1;
        wb_dat_i <= {20'h00000, d};
        do
            @(posedge clk_sys);
        while (wb_ack_o !== 1'b1);
        q = wb_dat_o[11:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_sys);
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [11:0] d);
        logic [11:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic chk_reg(input logic [7:0] a, input logic [11:0] e);
        logic [11:0] q;
        bus(1'b0, a, 12'h000, q);
        n_tests++;
        if (q !== e)
        begin
            $display("CHECK FAILED at %0t: reg %h got %h exp %h", $time, a, q, e);
            fail_count++;
        end
    endtask : chk_reg

    task automatic chk_st(input logic act, input logic irq);
        @(negedge clk_sys);
        n_tests++;
        if (conv_active !== act || conv_irq !== irq)
        begin
            $display("CHECK FAILED at %0t: active %b irq %b exp %b %b", $time, conv_active, conv_irq, act, irq);
            fail_count++;
        end
        @(posedge clk_sys);
    endtask : chk_st

    task automatic chk_pins(input logic [4:0] ch, input logic [1:0] rf, input logic lp, input logic sh);
        @(negedge clk_sys);
        n_tests++;
        if (analog_channel !== ch || analog_ref_select !== rf || analog_low_power !== lp || sample_hold !== sh)
        begin
            $display("CHECK FAILED at %0t: pins %h %h %b %b", $time, analog_channel, analog_ref_select,
                analog_low_power, sample_hold);
            fail_count++;
        end
        @(posedge clk_sys);
    endtask : chk_pins

    task automatic wait_for(input logic want_irq, input int lim);
        int n;
        n = 0;
        do
        begin
            @(negedge clk_sys);
            n++;
        end
        while ((want_irq ? conv_irq !== 1'b1 : conv_active !== 1'b0) && n < lim);
        @(posedge clk_sys);
    endtask : wait_for

    task automatic conv(input logic [11:0] cfg);
        wr(ADDR_CONFIG_ONE, cfg);
        wr(ADDR_CHAN_A, 12'h041);
    endtask : conv

    task automatic t_reset_vals();
        for (int i = 0; i < 8; i++)
            chk_reg(8'(i * 4), 12'h000);
        chk_st(1'b0, 1'b0);
    endtask : t_reset_vals

    task automatic t_layout();
        wr(ADDR_CONFIG_ONE, 12'h098);
        chk_reg(ADDR_CONFIG_ONE, 12'h098);
        wr(ADDR_STATUS_TWO, 12'h0ff);
        chk_reg(ADDR_STATUS_TWO, 12'h07b);
        wr(ADDR_CHAN_A, 12'h0df);
        chk_reg(ADDR_CHAN_A, 12'h05f);
        chk_st(1'b0, 1'b0);
        chk_pins(5'h1f, 2'h3, 1'b1, 1'b0);
        wr(ADDR_STATUS_TWO, 12'h000);
    endtask : t_layout

    task automatic t_res();
        logic [11:0] cfg [4] = '{12'h000, 12'h004, 12'h008, 12'h02e};
        logic [11:0] exp [4] = '{12'h0ab, 12'hab7, 12'h2ad, 12'hab7};
        analog_data <= 12'hab7;
        for (int i = 0; i < 4; i++)
        begin
            conv(cfg[i]);
            chk_pins(5'h01, 2'h0, 1'b0, 1'b1);
            chk_st(1'b1, 1'b0);
            wait_for(1'b0, 400);
            chk_st(1'b0, 1'b1);
            chk_reg(ADDR_CHAN_A, 12'h0c1);
            chk_reg(ADDR_RESULT_A, exp[i]);
            chk_st(1'b0, 1'b0);
        end
    endtask : t_res

    task automatic t_wait();
        wait_mode <= 1'b1;
        conv(12'h005);
        chk_st(1'b1, 1'b0);
        wait_for(1'b0, 200);
        chk_st(1'b0, 1'b1);
        chk_reg(ADDR_RESULT_A, 12'hab7);
        wr(ADDR_STATUS_TWO, 12'h040);
        analog_data <= 12'h3e1;
        hw_trigger <= 1'b1;
        repeat (8) @(posedge clk_sys);
        chk_st(1'b1, 1'b0);
        hw_trigger <= 1'b0;
        wait_for(1'b0, 200);
        chk_st(1'b0, 1'b1);
        chk_reg(ADDR_RESULT_A, 12'h3e1);
        wait_mode <= 1'b0;
        wr(ADDR_STATUS_TWO, 12'h000);
    endtask : t_wait

    task automatic t_stop_abort();
        analog_data <= 12'h5a5;
        conv(12'h004);
        normal_stop <= 1'b1;
        repeat (2) @(posedge clk_sys);
        chk_st(1'b0, 1'b0);
        normal_stop <= 1'b0;
        repeat (40) @(posedge clk_sys);
        chk_st(1'b0, 1'b0);
        chk_reg(ADDR_RESULT_A, 12'h3e1);
        chk_reg(ADDR_CONFIG_ONE, 12'h004);
        chk_reg(ADDR_CHAN_A, 12'h041);
    endtask : t_stop_abort

    task automatic t_async();
        wr(ADDR_CONFIG_ONE, 12'h007);
        wr(ADDR_STATUS_THREE, 12'h008);
        analog_data <= 12'h6c6;
        wr(ADDR_CHAN_A, 12'h041);
        normal_stop <= 1'b1;
        wait_for(1'b1, 400);
        chk_st(1'b1, 1'b1);
        analog_data <= 12'h111;
        repeat (200) @(posedge clk_sys);
        chk_reg(ADDR_RESULT_A, 12'h6c6);
        normal_stop <= 1'b0;
        low_power_stop <= 1'b1;
        repeat (3) @(posedge clk_sys);
        low_power_stop <= 1'b0;
        @(posedge clk_sys);
        t_reset_vals();
    endtask : t_async

    task automatic t_cmp();
        wr(ADDR_CONFIG_ONE, 12'h004);
        wr(ADDR_CMP_ONE, 12'h800);
        wr(ADDR_STATUS_TWO, 12'h030);
        analog_data <= 12'h123;
        wr(ADDR_CHAN_A, 12'h041);
        wait_for(1'b0, 200);
        chk_st(1'b0, 1'b0);
        chk_reg(ADDR_RESULT_A, 12'h000);
        analog_data <= 12'h900;
        wr(ADDR_CMP_TWO, 12'ha00);
        wr(ADDR_STATUS_TWO, 12'h038);
        wr(ADDR_CHAN_A, 12'h041);
        wait_for(1'b0, 200);
        chk_st(1'b0, 1'b1);
        chk_reg(ADDR_RESULT_A, 12'h900);
    endtask : t_cmp

    task automatic t_avg();
        wr(ADDR_STATUS_TWO, 12'h000);
        wr(ADDR_STATUS_THREE, 12'h004);
        analog_data <= 12'h3c3;
        wr(ADDR_CHAN_A, 12'h041);
        repeat (25) @(posedge clk_sys);
        chk_st(1'b1, 1'b0);
        wait_for(1'b0, 400);
        chk_st(1'b0, 1'b1);
        chk_reg(ADDR_RESULT_A, 12'h3c3);
    endtask : t_avg

    initial
    begin
        resetn = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h00000000;
        wait_mode = 1'b0;
        normal_stop = 1'b0;
        low_power_stop = 1'b0;
        hw_trigger = 1'b0;
        analog_data = 12'h000;
        repeat (6) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        t_reset_vals();
        t_layout();
        t_res();
        t_wait();
        t_stop_abort();
        t_async();
        t_cmp();
        t_avg();
        print_verdict();
    end
endmodule : alcc_conv_control_tb
